// file: core/vcal_pkg.sv
/*
  Package for the VCO band calibration and frequency-change controller.
  Holds the field codes, step counts and reset values shared by the design.
*/
package vcal_pkg;
  localparam int INT_W = 19;
  localparam int FRAC_W = 24;
  localparam int BAND_W = 8;
  localparam int VSP_W = 16;
  localparam int CNT_W = 24;
  localparam int CAL_STEPS = 8;
  localparam int XFER_CLKS = 20;
  localparam int VSP_CLKS = 16;
  localparam logic [1:0] FSM_DIV_RESET = 2'h2;
  localparam logic [BAND_W-1:0] BAND_RESET = 8'h00;
  localparam logic [BAND_W-1:0] BAND_MSB_FIRST = 8'h80;
  typedef enum logic [2:0] {VCAL_IDLE, VCAL_WAIT, VCAL_MEAS, VCAL_DECIDE, VCAL_XFER, VCAL_LOAD} vcal_state_t;
endpackage

// file: core/vcal_ctrl.sv
/*
  Calibration and frequency-change controller: band search by successive
  approximation, divider loading, and the internal VCO serial port.
  Assumes host write strobes are synchronous to clk_sys and that the
  phase detector tick and VCO count come from clk_sys-domain logic.
*/
// Notes on behaviour
// - Calibration clock sets only duration; it also clocks the 16-bit VCO port.
// - Resolution codes 0..7 map to exponents 0,1,2,3,5,6,7,8.
// - After band selection the pending value loads into the prescaler (integer mode) or modulator (fractional).
// - Selected 8-bit band is readable after every calibration run.
// - Manual band writes act at once when calibration is off; divider writes too.
// - With calibration disabled a VCO register write is forwarded immediately.
// - Forwarding a VCO register write takes 16 serial clock cycles.
// - Both clocks come from reference divided by 1, 4, 16 or 32.
// - Mode bit 1 selects fractional operation, 0 integer.
// - Fractional write with calibration on starts calibration, loads after it.
// - Fractional write with calibration off loads at once, band unchanged.
// - Integer write with calibration on starts calibration, loads after it.
// - Integer write with calibration off loads prescaler at once, no band change.
// - With calibration on, every frequency change write, even repeated, calibrates; here only a write matching frac_mode does, the other loads at once.
// - Eight steps, each wait, measurement window, then 20-clock serial transfer.
// - Window is two to the exponent PD periods; the PD period already holds the ratio.
`timescale 1ns/100ps
`default_nettype none
module vcal_ctrl
  import vcal_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ref_tick,
  input wire logic pd_tick,
  input wire logic [1:0] fsm_div_sel,
  input wire logic [2:0] resolution,
  input wire logic [6:0] wait_k,
  input wire logic cal_disable,
  input wire logic frac_mode,
  input wire logic int_wr,
  input wire logic [vcal_pkg::INT_W-1:0] int_wdata,
  input wire logic frac_wr,
  input wire logic [vcal_pkg::FRAC_W-1:0] frac_wdata,
  input wire logic vco_wr,
  input wire logic [vcal_pkg::VSP_W-1:0] vco_wdata,
  input wire logic [vcal_pkg::CNT_W-1:0] vco_count,
  input wire logic [vcal_pkg::CNT_W-1:0] expected_count,
  output logic vco_count_clear,
  output logic [vcal_pkg::INT_W-1:0] prescaler_value,
  output logic [vcal_pkg::FRAC_W-1:0] modulator_value,
  output logic [vcal_pkg::BAND_W-1:0] band_readback,
  output logic cal_busy,
  output logic vco_internal_serial_clock,
  output logic vco_internal_serial_data,
  output logic vco_internal_serial_load
);
  import vcal_pkg::*;

  logic rst_meta, rst_sync;
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // Exponent lookup; code 4 skips exponent 4.
  function automatic logic [3:0] res_exp(input logic [2:0] code);
    logic [3:0] e;
    e = (code < 3'h4) ? {1'b0, code} : 4'({1'b0, code} + 4'h1);
    return e;
  endfunction

  // Calibration clock tick: reference divided by 1, 4, 16 or 32.
  logic [4:0] div_cnt;
  logic fsm_tick;
  logic [5:0] div_max;
  always_comb
  begin
    unique case (fsm_div_sel)
      2'h0: div_max = 6'h00;
      2'h1: div_max = 6'h03;
      2'h2: div_max = 6'h0F;
      default: div_max = 6'h1F;
    endcase
  end
  always_ff @(posedge clk_sys or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      div_cnt <= 5'h00;
      fsm_tick <= 1'b0;
    end
    else
    begin
      fsm_tick <= 1'b0;
      if (ref_tick)
      begin
        if ({1'b0, div_cnt} >= div_max)
        begin
          div_cnt <= 5'h00;
          fsm_tick <= 1'b1;
        end
        else
          div_cnt <= div_cnt + 5'h01;
      end
    end
  end

  vcal_state_t state;
  logic [INT_W-1:0] pend_int;
  logic [FRAC_W-1:0] pend_frac;
  logic pend_is_int;
  logic [BAND_W-1:0] band, trial;
  logic [2:0] step;
  logic [11:0] phase_cnt;
  logic [VSP_W-1:0] shreg;
  logic [4:0] bits_left;
  logic [VSP_W-1:0] vco_word;
  logic vco_pend;
  logic start_cal;

  assign start_cal = !cal_disable && ((frac_wr && frac_mode) || (int_wr && !frac_mode));

  // Calibration sequencer and divider loading.
  always_ff @(posedge clk_sys or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      state <= VCAL_IDLE;
      pend_int <= '0;
      pend_frac <= '0;
      pend_is_int <= 1'b0;
      prescaler_value <= '0;
      modulator_value <= '0;
      band <= BAND_RESET;
      trial <= BAND_RESET;
      band_readback <= BAND_RESET;
      step <= 3'h0;
      phase_cnt <= 12'h000;
      cal_busy <= 1'b0;
      vco_count_clear <= 1'b0;
    end
    else
    begin
      vco_count_clear <= 1'b0;
      if (vco_wr && cal_disable)
        band <= vco_wdata[BAND_W-1:0];
      if (int_wr)
        pend_int <= int_wdata;
      if (frac_wr)
        pend_frac <= frac_wdata;
      if (start_cal)
      begin
        // A new request restarts the search from the top bit.
        pend_is_int <= !frac_mode;
        trial <= BAND_MSB_FIRST;
        step <= 3'h0;
        phase_cnt <= 12'h000;
        cal_busy <= 1'b1;
        state <= VCAL_WAIT;
      end
      else
      begin
        unique case (state)
          VCAL_IDLE: ;
          VCAL_WAIT:
            if (fsm_tick)
            begin
              // The largest multiplier asks for 2560 clocks, hence twelve count bits.
              if (phase_cnt >= 12'((XFER_CLKS * ({5'h00, wait_k} + 12'h001)) - 1))
              begin
                phase_cnt <= 12'h000;
                vco_count_clear <= 1'b1;
                state <= VCAL_MEAS;
              end
              else
                phase_cnt <= phase_cnt + 12'h001;
            end
          VCAL_MEAS:
            // A tick that meets the counter clear is ignored, so the window never closes empty.
            if (pd_tick && !vco_count_clear)
            begin
              // Window length counts PD periods, so ratio R is already inside.
              if (phase_cnt >= 12'((12'h001 << res_exp(resolution)) - 12'h001))
                state <= VCAL_DECIDE;
              else
                phase_cnt <= phase_cnt + 12'h001;
            end
          VCAL_DECIDE:
          begin
            trial <= (vco_count > expected_count) ? trial : (trial & ~(BAND_MSB_FIRST >> step));
            phase_cnt <= 12'h000;
            state <= VCAL_XFER;
          end
          VCAL_XFER:
            if (fsm_tick)
            begin
              if (phase_cnt == 12'(XFER_CLKS - 1))
              begin
                phase_cnt <= 12'h000;
                if (step == 3'(CAL_STEPS - 1))
                  state <= VCAL_LOAD;
                else
                begin
                  step <= step + 3'h1;
                  trial <= trial | (BAND_MSB_FIRST >> (step + 3'h1));
                  state <= VCAL_WAIT;
                end
              end
              else
                phase_cnt <= phase_cnt + 12'h001;
            end
          VCAL_LOAD:
          begin
            band <= trial;
            band_readback <= trial;
            if (pend_is_int)
              prescaler_value <= pend_int;
            else
              modulator_value <= pend_frac;
            cal_busy <= 1'b0;
            state <= VCAL_IDLE;
          end
        endcase
      end
      // Direct loads come last, so a host write wins over a calibration ending in the same cycle.
      if (int_wr && (cal_disable || frac_mode))
        prescaler_value <= int_wdata;
      if (frac_wr && (cal_disable || !frac_mode))
        modulator_value <= frac_wdata;
    end
  end

  // Internal VCO serial port: 16 bits, shifted on the calibration clock.
  always_ff @(posedge clk_sys or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      shreg <= '0;
      bits_left <= 5'h00;
      vco_word <= '0;
      vco_pend <= 1'b0;
      vco_internal_serial_clock <= 1'b0;
      vco_internal_serial_data <= 1'b0;
      vco_internal_serial_load <= 1'b0;
    end
    else
    begin
      vco_internal_serial_load <= 1'b0;
      vco_internal_serial_clock <= 1'b0;
      if (vco_wr)
      begin
        vco_word <= vco_wdata;
        vco_pend <= cal_disable;
      end
      else if (state == VCAL_LOAD && !start_cal)
      begin
        // Band field is replaced; address and identifier bits are kept.
        vco_word <= {vco_word[VSP_W-1:BAND_W], trial};
        vco_pend <= 1'b1;
      end
      if (fsm_tick)
      begin
        if (bits_left != 5'h00)
        begin
          vco_internal_serial_clock <= 1'b1;
          vco_internal_serial_data <= shreg[VSP_W-1];
          shreg <= {shreg[VSP_W-2:0], 1'b0};
          bits_left <= bits_left - 5'h01;
          if (bits_left == 5'h01)
            vco_internal_serial_load <= 1'b1;
        end
        else if (vco_pend && !vco_wr)
        begin
          shreg <= vco_word;
          bits_left <= 5'(VSP_CLKS);
          vco_pend <= 1'b0;
        end
      end
    end
  end

  property p_busy_on_start;
    @(posedge clk_sys) disable iff (!rst_sync) start_cal |=> cal_busy;
  endproperty
  a_busy_on_start: assert property (p_busy_on_start) else $error("calibration did not start");

  property p_frac_immediate;
    @(posedge clk_sys) disable iff (!rst_sync)
      (frac_wr && cal_disable) |=> (modulator_value == $past(frac_wdata));
  endproperty
  a_frac_immediate: assert property (p_frac_immediate) else $error("fractional not loaded at once");

  property p_int_immediate;
    @(posedge clk_sys) disable iff (!rst_sync)
      (int_wr && cal_disable) |=> (prescaler_value == $past(int_wdata));
  endproperty
  a_int_immediate: assert property (p_int_immediate) else $error("integer not loaded at once");

  property p_int_held;
    @(posedge clk_sys) disable iff (!rst_sync)
      (int_wr && !cal_disable && !frac_mode) |=> $stable(prescaler_value);
  endproperty
  a_int_held: assert property (p_int_held) else $error("integer loaded before calibration");

  property p_frac_held;
    @(posedge clk_sys) disable iff (!rst_sync)
      (frac_wr && !cal_disable && frac_mode) |=> $stable(modulator_value);
  endproperty
  a_frac_held: assert property (p_frac_held) else $error("fractional loaded before calibration");

  property p_readback;
    @(posedge clk_sys) disable iff (!rst_sync)
      (state == VCAL_LOAD && !start_cal) |=> (band_readback == band) && !cal_busy;
  endproperty
  a_readback: assert property (p_readback) else $error("band readback not updated");

  property p_manual_band;
    @(posedge clk_sys) disable iff (!rst_sync)
      (vco_wr && cal_disable && state != VCAL_LOAD) |=> (band == $past(vco_wdata[BAND_W-1:0]));
  endproperty
  a_manual_band: assert property (p_manual_band) else $error("manual band not applied");

  property p_mode_decides;
    @(posedge clk_sys) disable iff (!rst_sync)
      (frac_wr && !frac_mode && !cal_disable) |=> !cal_busy || $past(cal_busy);
  endproperty
  a_mode_decides: assert property (p_mode_decides) else $error("integer mode calibrated on fractional write");

  c_cal_done: cover property (@(posedge clk_sys) disable iff (!rst_sync) state == VCAL_LOAD);
  c_serial_load: cover property (@(posedge clk_sys) disable iff (!rst_sync) vco_internal_serial_load);
  c_manual: cover property (@(posedge clk_sys) disable iff (!rst_sync) vco_wr && cal_disable);
endmodule // vcal_ctrl
`default_nettype wire

// file: tb/vcal_vco_model.sv
/*
  VCO-side stand-in: reference and detector ticks, a VCO cycle counter and
  a receiver for the internal serial port.
  Assumes one clk_sys domain and a reference divider of one.
*/
`timescale 1ns/100ps
`default_nettype none
module vcal_vco_model
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic count_clear,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic sload,
  output logic ref_tick,
  output logic pd_tick,
  output logic [vcal_pkg::CNT_W-1:0] vco_count,
  output logic [vcal_pkg::VSP_W-1:0] rx_word
);
  import vcal_pkg::*;
  logic [VSP_W-1:0] shift;
  // With the reference divider at one the detector ticks with the reference.
  assign pd_tick = ref_tick;
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ref_tick <= 1'b0;
      vco_count <= '0;
    end
    else
    begin
      ref_tick <= !ref_tick;
      vco_count <= count_clear ? '0 : vco_count + 24'h000001;
    end
  end
  // The load pulse comes with the last bit, so that bit joins the word here.
  always_ff @(posedge clk_sys)
  begin
    if (sclk)
      shift <= {shift[VSP_W-2:0], sdata};
    if (sload)
      rx_word <= {shift[VSP_W-2:0], sdata};
  end
endmodule // vcal_vco_model
`default_nettype wire

// file: tb/test_vcal_ctrl.sv
/*
  Self-checking bench for the calibration controller: forwarding, direct
  loads, band search and window length.
  Assumes the VCO stand-in model for ticks, counts and serial capture.
*/
`timescale 1ns/100ps
`default_nettype none
module test_vcal_ctrl;
  import vcal_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic ref_tick, pd_tick, vco_count_clear, cal_busy, sclk, sdata, sload;
  logic [1:0] fsm_div_sel = 2'h1;
  logic [2:0] resolution = 3'h0;
  logic [6:0] wait_k = 7'h00;
  logic cal_disable = 1'b1;
  logic frac_mode = 1'b0;
  logic int_wr = 1'b0;
  logic frac_wr = 1'b0;
  logic vco_wr = 1'b0;
  logic [INT_W-1:0] int_wdata = '0;
  logic [FRAC_W-1:0] frac_wdata = '0;
  logic [VSP_W-1:0] vco_wdata = '0;
  logic [VSP_W-1:0] rx_word;
  logic [CNT_W-1:0] vco_count;
  logic [CNT_W-1:0] expected_count = '0;
  logic [INT_W-1:0] prescaler_value;
  logic [FRAC_W-1:0] modulator_value;
  logic [BAND_W-1:0] band_readback;
  logic loaded = 1'b0;
  logic [31:0] a;
  logic [31:0] b;
  int n_errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  int last = 0;
  int nbits = 0;
  int gap_exp = 0;
  int dur[8];
  int ratio[4] = '{1, 4, 16, 32};
  int expo[8] = '{0, 1, 2, 3, 5, 6, 7, 8};

  vcal_ctrl dut (.clk_sys(clk_sys), .rst_b(rst_b), .ref_tick(ref_tick), .pd_tick(pd_tick),
    .fsm_div_sel(fsm_div_sel), .resolution(resolution), .wait_k(wait_k), .cal_disable(cal_disable),
    .frac_mode(frac_mode), .int_wr(int_wr), .int_wdata(int_wdata), .frac_wr(frac_wr),
    .frac_wdata(frac_wdata), .vco_wr(vco_wr), .vco_wdata(vco_wdata), .vco_count(vco_count),
    .expected_count(expected_count), .vco_count_clear(vco_count_clear),
    .prescaler_value(prescaler_value), .modulator_value(modulator_value), .band_readback(band_readback),
    .cal_busy(cal_busy), .vco_internal_serial_clock(sclk), .vco_internal_serial_data(sdata),
    .vco_internal_serial_load(sload));
  vcal_vco_model vco (.clk_sys(clk_sys), .rst_b(rst_b), .count_clear(vco_count_clear), .sclk(sclk),
    .sdata(sdata), .sload(sload), .ref_tick(ref_tick), .pd_tick(pd_tick), .vco_count(vco_count),
    .rx_word(rx_word));

  initial
  begin
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    if (n_errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  function automatic logic [31:0] cur();
    return frac_mode ? 32'(modulator_value) : 32'(prescaler_value);
  endfunction

  function automatic logic [31:0] fit(input logic [31:0] v);
    return frac_mode ? 32'(v[FRAC_W-1:0]) : 32'(v[INT_W-1:0]);
  endfunction

  // A step may round its window up to one calibration clock, hence the slack.
  function automatic logic win_ok(input int r);
    int e;
    e = dur[r] - dur[0] - 16 * ((1 << expo[r]) - 1);
    return e <= 64 && e >= -64;
  endfunction

  task automatic wr(input int k, input logic [31:0] d);
    int_wdata = d[INT_W-1:0];
    frac_wdata = d[FRAC_W-1:0];
    vco_wdata = d[VSP_W-1:0];
    int_wr = (k == 0);
    frac_wr = (k == 1);
    vco_wr = (k == 2);
    @(negedge clk_sys);
  endtask

  task automatic drop();
    int_wr = 1'b0;
    frac_wr = 1'b0;
    vco_wr = 1'b0;
    @(negedge clk_sys);
  endtask

  task automatic cal_run(input logic [31:0] v, output int n);
    logic [31:0] old;
    old = cur();
    n = 0;
    wr(int'(frac_mode), v);
    check(cal_busy, 1'b1);
    drop();
    while (cal_busy === 1'b1 && n < 20000)
    begin
      check(cur(), old);
      n++;
      @(negedge clk_sys);
    end
    check(cur(), fit(v));
  endtask

  always @(posedge clk_sys)
  begin
    cyc++;
    if (sclk)
    begin
      if (nbits > 0 && gap_exp > 0)
        check(cyc - last, gap_exp);
      nbits++;
      last = cyc;
    end
    if (sload)
      loaded = 1'b1;
  end

  initial
  begin
    #400000;
    n_errors++;
    complete_run();
  end

  initial
  begin
    void'($urandom(32'hCB85));
    repeat (4) @(negedge clk_sys);
    rst_b = 1'b1;
    repeat (3) @(negedge clk_sys);
    // Ratio 1 would run the calibration clock above 50 MHz, so it is skipped.
    for (int d = 1; d < 4; d++)
    begin
      fsm_div_sel = d[1:0];
      gap_exp = 2 * ratio[d];
      nbits = 0;
      loaded = 1'b0;
      a = $urandom;
      wr(2, a);
      drop();
      for (int i = 0; i < 3000 && !loaded; i++)
        @(negedge clk_sys);
      check(nbits, 16);
      check(rx_word, a[VSP_W-1:0]);
    end
    gap_exp = 0;
    fsm_div_sel = 2'h1;
    a = $urandom | 32'h20;
    b = $urandom | 32'h20;
    wr(0, a);
    check(prescaler_value, a[INT_W-1:0]);
    wr(0, b);
    drop();
    check(prescaler_value, b[INT_W-1:0]);
    check(band_readback, BAND_RESET);
    frac_mode = 1'b1;
    wr(1, a);
    drop();
    check(modulator_value, a[FRAC_W-1:0]);
    check(cal_busy, 1'b0);
    cal_disable = 1'b0;
    for (int j = 0; j < 4; j++)
    begin
      frac_mode = j[0];
      wait_k = 7'($urandom_range(1, 0));
      expected_count = j[1] ? 24'hFFFFFF : 24'h000000;
      a = $urandom | 32'h20;
      cal_run(a, dur[0]);
      check(band_readback, j[1] ? 8'h00 : 8'hFF);
    end
    frac_mode = 1'b0;
    wr(1, b);
    check(cal_busy, 1'b0);
    drop();
    frac_mode = 1'b1;
    cal_run(a, dur[0]);
    wait_k = 7'h00;
    expected_count = '0;
    for (int r = 0; r < 8; r++)
    begin
      resolution = r[2:0];
      cal_run(a, dur[r]);
      check(win_ok(r), 1'b1);
    end
    complete_run();
  end
endmodule // test_vcal_ctrl
`default_nettype wire
